//--- rtl/capsh_addr_phase.sv
`timescale 1ns/10ps
// Address phase, strobe, and snoop hold handling of the external bus
module capsh_addr_phase
    import capsh_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic addr_bit20_mask_n,
    input wire logic addr_hold_req,
    input wire logic bus_hold,
    input wire logic ext_snoop_strobe_n,
    input wire logic [CAPSH_LW-1:0] line_addr_lines_in,
    input wire logic cyc_valid,
    input wire capsh_req_t cyc_req,
    input wire logic cyc_done,
    input wire logic snoop_hit_dirty,
    input wire logic [CAPSH_LW-1:0] snoop_victim_line,
    output logic cyc_accept,
    output logic [CAPSH_AW-1:0] phys_addr_lines,
    output logic phys_addr_oe,
    output logic addr_strobe_n,
    output logic addr_strobe_oe,
    output logic [3:0] cyc_def_out,
    output logic [CAPSH_AW-1:0] lookup_addr,
    output logic snoop_valid,
    output logic [CAPSH_LW-1:0] snoop_line,
    output logic snoop_hit_modified_n,
    output logic data_bus_active
);
    capsh_state_t state; // Bus cycle sequencer
    capsh_state_t next_state;
    logic window; // Snoop strobe sampling allowed
    logic snoop_gap; // Clock after a taken snoop
    logic wb_pending; // Write-back owed for a modified hit
    logic [CAPSH_LW-1:0] wb_line; // Line to write back
    logic [CAPSH_AW-1:0] masked_addr; // Core address after bit-20 masking
    logic start_wb; // Launch write-back cycle
    logic start_req; // Launch core cycle
    logic snoop_take; // Snoop strobe accepted this clock

    capsh_snoop_timer #(
        .WAIT(CAPSH_SNOOP_WAIT)
    ) u_timer (
        .core_clk(core_clk),
        .rst(rst),
        .hold(addr_hold_req),
        .window(window)
    );

    // Bit 20 cleared while mask low, so addresses wrap at 1 Mbyte
    always_comb begin
        masked_addr = cyc_req.addr;
        if (!addr_bit20_mask_n) begin
            masked_addr[CAPSH_A20_POS] = 1'b0;
        end
    end

    // Snoop accepted only in window, not in the clock after another or during a hit
    assign snoop_take = window && !ext_snoop_strobe_n && !snoop_gap
        && snoop_hit_modified_n;
    // Write-back may start under address hold but not bus hold
    assign start_wb = (state == CAPSH_IDLE) && wb_pending && !bus_hold && !rst;
    // Core cycles wait until both holds are gone
    assign start_req = (state == CAPSH_IDLE) && !wb_pending && cyc_valid
        && !addr_hold_req && !bus_hold && !rst;

    // Sequencer next state
    always_comb begin
        next_state = state;
        case (state)
            CAPSH_IDLE: begin
                if (start_wb || start_req) begin
                    next_state = CAPSH_ADDR;
                end
            end
            CAPSH_ADDR: begin
                next_state = CAPSH_DATA;
            end
            CAPSH_DATA: begin
                // Data finishes even under address hold
                if (cyc_done) begin
                    next_state = CAPSH_IDLE;
                end
            end
            default: begin
                next_state = CAPSH_IDLE;
            end
        endcase
    end

    // Sequencer state register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state <= CAPSH_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Address and strobe pins; strobe only in the one address clock
    always_ff @(posedge core_clk) begin
        if (rst) begin
            phys_addr_lines <= CAPSH_ADDR_RST;
            addr_strobe_n <= 1'b1;
            cyc_def_out <= 4'h0;
        end else if (start_wb) begin
            phys_addr_lines <= {wb_line, 2'b00};
            addr_strobe_n <= 1'b0;
            cyc_def_out <= 4'hF;
        end else if (start_req) begin
            phys_addr_lines <= masked_addr;
            addr_strobe_n <= 1'b0;
            cyc_def_out <= cyc_req.cyc_def;
        end else begin
            addr_strobe_n <= 1'b1;
        end
    end

    // Drive enables: float on holds, but write-back overrides address hold
    always_ff @(posedge core_clk) begin
        if (start_wb) begin
            phys_addr_oe <= 1'b1;
        end else if (bus_hold || addr_hold_req) begin
            phys_addr_oe <= 1'b0;
        end else if (rst) begin
            phys_addr_oe <= 1'b0;
        end else if (start_req) begin
            // After a hold the lines must come back with the strobe, not a clock late
            phys_addr_oe <= 1'b1;
        end else if (next_state == CAPSH_IDLE && state == CAPSH_IDLE) begin
            phys_addr_oe <= 1'b1;
        end
    end

    // Strobe pin floats under bus hold or reset only
    always_ff @(posedge core_clk) begin
        addr_strobe_oe <= !bus_hold && !rst;
    end

    // Core handshake and data bus activity flag
    always_ff @(posedge core_clk) begin
        cyc_accept <= start_req && !rst;
        data_bus_active <= !rst && (next_state == CAPSH_DATA);
    end

    // Snoop sampling of incoming line address, one clock gap afterwards
    always_ff @(posedge core_clk) begin
        snoop_gap <= snoop_take;
        snoop_valid <= snoop_take;
        if (snoop_take) begin
            snoop_line <= line_addr_lines_in;
        end
    end

    // Modified-hit bookkeeping; set wins over clear in the same clock
    always_ff @(posedge core_clk) begin
        if (snoop_hit_dirty && snoop_valid) begin
            wb_pending <= 1'b1;
            wb_line <= snoop_victim_line;
            snoop_hit_modified_n <= 1'b0;
        end else if (rst && !addr_hold_req) begin
            wb_pending <= 1'b0;
            snoop_hit_modified_n <= 1'b1;
        end else if (start_wb) begin
            wb_pending <= 1'b0;
        end else if (state == CAPSH_DATA && cyc_done && !wb_pending) begin
            snoop_hit_modified_n <= 1'b1;
        end
    end

    // Cache lookup address also masked
    always_ff @(posedge core_clk) begin
        lookup_addr <= masked_addr;
    end

    AST_STROBE_ONE: assert property (@(posedge core_clk) disable iff (rst)
        !addr_strobe_n |=> addr_strobe_n)
        else $error("strobe longer than one clock");
    AST_STROBE_ADDR: assert property (@(posedge core_clk) disable iff (rst)
        !addr_strobe_n |-> phys_addr_oe)
        else $error("strobe without driven address");
    AST_STROBE_NEW: assert property (@(posedge core_clk) disable iff (rst)
        $fell(addr_strobe_n) |-> $rose(phys_addr_oe) || $past(phys_addr_oe))
        else $error("strobe not with address");
    AST_HOLD_FLOAT: assert property (@(posedge core_clk)
        addr_hold_req && !snoop_hit_dirty && wb_pending == 1'b0 |=> !phys_addr_oe)
        else $error("address driven after hold");
    AST_BUS_FLOAT: assert property (@(posedge core_clk)
        bus_hold |=> !phys_addr_oe && !addr_strobe_oe)
        else $error("pins driven in bus hold");
    AST_A20: assert property (@(posedge core_clk) disable iff (rst)
        start_req && !addr_bit20_mask_n |=> !phys_addr_lines[CAPSH_A20_POS])
        else $error("bit 20 not masked");
    AST_WINDOW: assert property (@(posedge core_clk)
        snoop_take |-> $past(addr_hold_req, 2) && $past(addr_hold_req))
        else $error("snoop sampled too early");
    AST_WB: assert property (@(posedge core_clk) disable iff (rst)
        start_wb |=> !addr_strobe_n ##1 state == CAPSH_DATA)
        else $error("write-back not launched");
    AST_DATA_RUN: assert property (@(posedge core_clk) disable iff (rst)
        state == CAPSH_DATA && !cyc_done |=> state == CAPSH_DATA)
        else $error("data phase dropped");
    CVR_SNOOP: cover property (@(posedge core_clk) snoop_take);
    CVR_WB: cover property (@(posedge core_clk) start_wb && addr_hold_req);
    CVR_CYCLE: cover property (@(posedge core_clk) start_req ##1 !addr_strobe_n);
endmodule

//--- rtl/capsh_pkg.sv
package capsh_pkg;
    localparam int CAPSH_AW = 30;           // Address lines 31..2
    localparam int CAPSH_LW = 28;           // Line address lines 31..4
    localparam int CAPSH_A20_POS = 18;      // Bit 20 within the 31..2 field
    localparam int CAPSH_SNOOP_WAIT = 2;    // Clocks from hold to first snoop sample
    localparam logic [29:0] CAPSH_ADDR_RST = 30'h0;

    // Cycle request from the core
    typedef struct packed {
        logic [CAPSH_AW-1:0] addr;
        logic [3:0] cyc_def;
    } capsh_req_t;

    // Pin group for the address bus
    typedef struct packed {
        logic [CAPSH_AW-1:0] addr_out;
        logic addr_oe;
        logic strobe_n;
        logic strobe_oe;
        logic [3:0] cyc_def;
    } capsh_pins_t;

    typedef enum logic [1:0] {
        CAPSH_IDLE = 2'b00,
        CAPSH_ADDR = 2'b01,
        CAPSH_DATA = 2'b10
    } capsh_state_t;
endpackage

//--- rtl/capsh_snoop_timer.sv
`timescale 1ns/10ps
// Counts clocks since hold asserted; opens snoop sampling window
module capsh_snoop_timer
    import capsh_pkg::*;
#(
    parameter int WAIT = CAPSH_SNOOP_WAIT
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic hold,
    output logic window
);
    logic [1:0] count; // Saturating clock count under hold

    // Restart on every hold release; reset does not clear it
    always_ff @(posedge core_clk) begin
        if (!hold) begin
            count <= 2'h0;
        end else if (count != WAIT[1:0]) begin
            count <= count + 2'h1;
        end
    end

    // First sample at the second clock after hold assertion
    assign window = hold && (count == WAIT[1:0]);
endmodule

//--- verification/capsh_snoop_master.sv
`timescale 1ns/10ps
// Chipset model: takes the address bus, offers one snoop line, then lets go
module capsh_snoop_master
    import capsh_pkg::*;
(
    input wire logic core_clk,
    input wire logic start,
    input wire logic keep,
    input wire logic [CAPSH_LW-1:0] line,
    output logic hold,
    output logic strobe_n,
    output logic [CAPSH_LW-1:0] lines_out
);
    int cnt; // Clocks since hold rose
    initial begin
        hold = 1'b0;
        strobe_n = 1'b1;
        lines_out = '0;
        cnt = 0;
    end
    // Strobe is seen in the design's second clock of hold; idle lines show inverted junk
    always @(posedge core_clk) begin
        if (start && !hold) begin
            hold <= 1'b1;
            cnt <= 0;
        end else if (hold) begin
            cnt <= cnt + 1;
            strobe_n <= !(cnt == 1);
            lines_out <= (cnt == 1) ? line : ~lines_out;
            if (cnt >= 3 && !keep) begin
                hold <= 1'b0;
            end
        end
    end
endmodule

//--- verification/cpu_address_phase_snoop_hold_bench.sv
`timescale 1ns/10ps
// Drives core requests and a chipset snoop, checks the pin behaviour
module cpu_address_phase_snoop_hold_bench import capsh_pkg::*;;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic mask_n = 1'b1; // Held high at reset release
    logic bus_hold = 1'b0;
    logic cyc_valid = 1'b0;
    logic cyc_done = 1'b0;
    logic dirty = 1'b0; // Cache model: next snoop hits a modified line
    logic go = 1'b0;
    logic keep = 1'b1;
    capsh_req_t req = '0;
    logic [CAPSH_LW-1:0] victim = 28'hABCDEF1;
    logic [CAPSH_LW-1:0] sl_set = 28'h123456A;
    logic hold, snp_n, accept, aoe, strobe_n, soe, svalid, hit_mod_n, dba, hit;
    logic [CAPSH_LW-1:0] lin, sline;
    logic [CAPSH_AW-1:0] pa, look;
    logic [3:0] cdef;
    int n_errors = 0;
    int check_count = 0;
    always #5 core_clk = ~core_clk;
    assign hit = svalid & dirty; // Hit answer comes with the lookup pulse
    capsh_snoop_master chipset (.core_clk(core_clk), .start(go), .keep(keep),
        .line(sl_set), .hold(hold), .strobe_n(snp_n), .lines_out(lin));
    capsh_addr_phase dut (.core_clk(core_clk), .rst(rst), .addr_bit20_mask_n(mask_n),
        .addr_hold_req(hold), .bus_hold(bus_hold), .ext_snoop_strobe_n(snp_n),
        .line_addr_lines_in(lin), .cyc_valid(cyc_valid), .cyc_req(req),
        .cyc_done(cyc_done), .snoop_hit_dirty(hit), .snoop_victim_line(victim),
        .cyc_accept(accept), .phys_addr_lines(pa), .phys_addr_oe(aoe),
        .addr_strobe_n(strobe_n), .addr_strobe_oe(soe), .cyc_def_out(cdef),
        .lookup_addr(look), .snoop_valid(svalid), .snoop_line(sline),
        .snoop_hit_modified_n(hit_mod_n), .data_bus_active(dba));
    // Verdict, also reached when a wait runs out
    task automatic results();
        $display("errors %0d, checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [CAPSH_AW-1:0] exp,
                       input logic [CAPSH_AW-1:0] got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic tick();
        @(posedge core_clk);
        #1;
    endtask
    // Bounded wait for a level; running out ends the run
    task automatic wait_lvl(ref logic sig, input logic lvl, input string what);
        #1; // Never judge an output in the time step of its launching edge
        for (int i = 0; i < 20 && sig !== lvl; i++) tick();
        chk(what, 30'(lvl), 30'(sig));
        if (sig !== lvl) results();
    endtask
    task automatic pulse_done();
        @(posedge core_clk);
        cyc_done <= 1'b1;
        @(posedge core_clk);
        cyc_done <= 1'b0;
    endtask
    // One core cycle; mask applied a clock ahead of the request
    task automatic run_cycle(input logic [CAPSH_AW-1:0] a, input logic m, input bit fin);
        logic [CAPSH_AW-1:0] e;
        e = m ? a : a & ~(30'h1 << CAPSH_A20_POS);
        @(posedge core_clk);
        mask_n <= m;
        @(posedge core_clk);
        req <= '{addr: a, cyc_def: 4'h6};
        cyc_valid <= 1'b1;
        wait_lvl(accept, 1'b1, "cyc_accept");
        chk("strobe", 30'h0, 30'(strobe_n));
        chk("address", e, pa);
        chk("lookup", e, look);
        chk("address oe", 30'h1, 30'(aoe));
        chk("cycle type", 30'h6, 30'(cdef));
        @(posedge core_clk);
        cyc_valid <= 1'b0;
        #1;
        chk("strobe one clock", 30'h1, 30'(strobe_n));
        chk("data bus", 30'h1, 30'(dba));
        if (fin) pulse_done();
    endtask
    // Snoop under address hold, optionally hitting a modified line
    task automatic snoop(input logic h, input logic open);
        @(posedge core_clk);
        dirty <= h;
        go <= 1'b1;
        keep <= 1'b1;
        wait_lvl(hold, 1'b1, "hold");
        @(posedge core_clk);
        go <= 1'b0;
        #1;
        chk("address float", 30'h0, 30'(aoe));
        chk("data bus in hold", 30'(open), 30'(dba));
        tick();
        tick();
        chk("snoop valid", 30'h1, 30'(svalid));
        chk("snoop line", 30'(sl_set), 30'(sline));
        if (h) begin
            wait_lvl(hit_mod_n, 1'b0, "hit modified");
            chk("strobe waits", 30'h1, 30'(strobe_n));
            if (open) pulse_done();
            wait_lvl(strobe_n, 1'b0, "write-back strobe");
            chk("wb oe", 30'h1, 30'(aoe));
            chk("wb hold", 30'h1, 30'(hold));
            chk("wb address", {victim, 2'b00}, pa);
            chk("wb type", 30'hF, 30'(cdef));
            tick();
            chk("wb strobe one clock", 30'h1, 30'(strobe_n));
            pulse_done();
            wait_lvl(hit_mod_n, 1'b1, "hit cleared");
        end
        @(posedge core_clk);
        keep <= 1'b0;
        dirty <= 1'b0;
        wait_lvl(hold, 1'b0, "hold released");
    endtask
    // Bus hold floats strobe and address, no cycle taken
    task automatic bus_hold_float();
        @(posedge core_clk);
        bus_hold <= 1'b1;
        tick();
        tick();
        chk("strobe oe", 30'h0, 30'(soe));
        chk("address oe", 30'h0, 30'(aoe));
        @(posedge core_clk);
        bus_hold <= 1'b0;
    endtask
    initial begin
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        run_cycle(30'h0004_0123, 1'b1, 1'b1);
        run_cycle(30'h0004_0123, 1'b0, 1'b1);
        run_cycle(30'h0000_4567, 1'b1, 1'b0);
        snoop(1'b1, 1'b1);
        bus_hold_float();
        @(posedge core_clk);
        rst <= 1'b1;
        snoop(1'b0, 1'b0);
        @(posedge core_clk);
        rst <= 1'b0;
        run_cycle(30'h0004_0ABC, 1'b1, 1'b1);
        results();
    end
endmodule
